/* File: inc/adcstc_pkg.sv */
package adcstc_pkg;
	// register offsets
	localparam logic [7:0] OFS_FREEZE     = 8'h63;
	localparam logic [7:0] OFS_TIMING     = 8'h64;
	localparam logic [7:0] OFS_SEQUENCE   = 8'h65;
	localparam logic [7:0] OFS_STATUS     = 8'h66;
	localparam logic [7:0] OFS_FLAGS      = 8'h67;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h71;
	// reset values
	localparam logic [7:0] RST_FREEZE   = 8'h00;
	localparam logic [7:0] RST_TIMING   = 8'h01;
	localparam logic [7:0] RST_SEQUENCE = 8'h00;
	// field positions
	localparam int TIM_RES_BIT  = 7;
	localparam int TIM_SMP_LSB  = 5;
	localparam int SEQ_LEN_BIT  = 6;
	localparam int SEQ_SCAN_BIT = 5;
	localparam int SEQ_MULTICHANNEL_ENABLE_BIT = 4;
	localparam int IRQ_SEQ_BIT  = 0;
	localparam int IRQ_CONV_BIT = 1;
	// freeze codes
	localparam logic [1:0] FRZ_RUN    = 2'h0;
	localparam logic [1:0] FRZ_FINISH = 2'h2;
	localparam logic [1:0] FRZ_NOW    = 2'h3;
	// phase lengths in converter clocks
	localparam logic [4:0] INIT_SAMPLE_CLKS = 5'h02;
	localparam logic [4:0] TRANSFER_CLKS    = 5'h04;
	localparam logic [4:0] RESOLVE_CLKS     = 5'h0a;
	localparam logic [4:0] RESOLVE_10_EXTRA = 5'h02;
	typedef enum logic [2:0] {IDLE, INIT_SAMPLE, TRANSFER, FINAL_SAMPLE, RESOLVE} adcstc_phase_type;
endpackage : adcstc_pkg

/* File: hdl/adcstc_prescaler.sv */
module adcstc_prescaler (
	input  wire logic       clk,       // p clock
	input  wire logic       arst_n,    // async reset
	input  wire logic [4:0] prescale,  // prescale field
	output logic            tick       // one pulse per converter clock
);
	logic [4:0] count;
	logic       half;
	logic [4:0] limit;

	// code zero wraps every clock, so the halving stage alone gives divide by two
	assign limit = (prescale == 5'h00) ? 5'h00 : prescale;

	// modulo counter by prescale plus one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			count <= 5'h00;
		else if (count >= limit)
			count <= 5'h00;
		else
			count <= count + 5'h01;
	end

	// divide-by-two stage keeps the converter clock symmetric
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			half <= 1'b0;
		else if (count >= limit)
			half <= ~half;
	end

	// tick on each rising edge of the derived clock
	assign tick = (count >= limit) && !half;
endmodule : adcstc_prescaler

/* File: hdl/adcstc_phase_timer.sv */
module adcstc_phase_timer (
	input  wire logic                            clk,        // p clock
	input  wire logic                            arst_n,     // async reset
	input  wire logic                            start,      // begin a conversion
	input  wire logic                            abort,      // kill conversion
	input  wire logic                            tick,       // converter clock pulse
	input  wire logic                            hold,       // freeze, no progress
	input  wire logic [1:0]                      smp_sel,    // final sample code
	input  wire logic                            ten_bit,    // 10-bit resolution
	output adcstc_pkg::adcstc_phase_type         phase,      // current phase
	output logic                                 done        // conversion finished pulse
);
	logic [4:0] left;

	function automatic logic [4:0] final_len(input logic [1:0] code);
		final_len = 5'(5'h02 << code);
	endfunction : final_len

	// phase sequencer; each count is in converter clocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= adcstc_pkg::IDLE;
			left  <= 5'h00;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				phase <= adcstc_pkg::IDLE;
			end else if (start) begin
				phase <= adcstc_pkg::INIT_SAMPLE;
				left  <= adcstc_pkg::INIT_SAMPLE_CLKS;
			end else if (tick && !hold && phase != adcstc_pkg::IDLE) begin
				if (left > 5'h01) begin
					left <= left - 5'h01;
				end else begin
					case (phase)
						adcstc_pkg::INIT_SAMPLE: begin
							phase <= adcstc_pkg::TRANSFER;
							left  <= adcstc_pkg::TRANSFER_CLKS;
						end
						adcstc_pkg::TRANSFER: begin
							phase <= adcstc_pkg::FINAL_SAMPLE;
							left  <= final_len(smp_sel);
						end
						adcstc_pkg::FINAL_SAMPLE: begin
							phase <= adcstc_pkg::RESOLVE;
							// 10-bit mode adds two clocks to every conversion
							left  <= ten_bit ? adcstc_pkg::RESOLVE_CLKS
								+ adcstc_pkg::RESOLVE_10_EXTRA
								: adcstc_pkg::RESOLVE_CLKS;
						end
						adcstc_pkg::RESOLVE: begin
							phase <= adcstc_pkg::IDLE;
							done  <= 1'b1;
						end
						default: phase <= adcstc_pkg::IDLE;
					endcase
				end
			end
		end
	end
endmodule : adcstc_phase_timer

/* File: hdl/adcstc_control.sv */
module adcstc_control (
	input  wire logic       clk,              // p clock, 100 MHz
	input  wire logic       arst_n,           // async reset, active low
	input  wire logic [7:0] addr,             // register address
	input  wire logic [7:0] wdata,            // write data
	input  wire logic       wr,               // write strobe
	input  wire logic       rd,               // read strobe
	output logic      [7:0] rdata,            // read data, cycle after rd
	input  wire logic       background_debug_active, // debug mode, from pin
	input  wire logic [7:0] result_read,      // one pulse per result register read
	output logic      [3:0] channel,          // channel to sample
	output logic      [2:0] result_index,     // result slot being converted
	output logic            sampling,         // sample switch closed
	output logic            ten_bit_resolution, // 10-bit conversion mode
	output logic            conv_done,        // result ready pulse
	output logic      [7:0] conversion_done_flag, // per-result done flags
	output logic            sequence_done_flag,   // sequence complete
	output logic            irq               // level interrupt
);
	////////////////////////////////////////////////////////////////////
	logic [1:0] freeze_sel;
	logic [7:0] timing;
	logic [6:0] seq;
	logic       running;
	logic       first_seq;
	logic [2:0] conv_idx;
	logic       dbg_meta;
	logic       dbg;
	logic       tick;
	logic       done;
	logic       start_conv;
	logic       abort;
	logic       hold;
	logic       last;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	adcstc_pkg::adcstc_phase_type phase;

	wire wr_freeze = wr && addr == adcstc_pkg::OFS_FREEZE;
	wire wr_timing = wr && addr == adcstc_pkg::OFS_TIMING;
	wire wr_seq    = wr && addr == adcstc_pkg::OFS_SEQUENCE;

	////////////////////////////////////////////////////////////////////
	// debug level comes from a pin, so it is synchronised
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dbg_meta <= 1'b0;
			dbg      <= 1'b0;
		end else begin
			dbg_meta <= background_debug_active;
			dbg      <= dbg_meta;
		end
	end

	// freeze now stops every phase; finish mode lets the current conversion end
	assign hold = dbg && (freeze_sel == adcstc_pkg::FRZ_NOW);

	////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			freeze_sel <= adcstc_pkg::RST_FREEZE[1:0];
			timing     <= adcstc_pkg::RST_TIMING;
			seq        <= adcstc_pkg::RST_SEQUENCE[6:0];
		end else begin
			if (wr_freeze)
				freeze_sel <= wdata[1:0];
			if (wr_timing)
				timing <= wdata;
			if (wr_seq)
				seq <= wdata[6:0];
		end
	end

	assign ten_bit_resolution = timing[adcstc_pkg::TIM_RES_BIT];

	////////////////////////////////////////////////////////////////////
	adcstc_prescaler u_prescaler (
		.clk      (clk),
		.arst_n   (arst_n),
		.prescale (timing[4:0]),
		.tick     (tick)
	);

	adcstc_phase_timer u_timer (
		.clk      (clk),
		.arst_n   (arst_n),
		.start    (start_conv),
		.abort    (abort),
		.tick     (tick),
		.hold     (hold),
		.smp_sel  (timing[adcstc_pkg::TIM_SMP_LSB +: 2]),
		.ten_bit  (ten_bit_resolution),
		.phase    (phase),
		.done     (done)
	);

	////////////////////////////////////////////////////////////////////
	// a timing write or a new sequence write kills the conversion in flight
	assign abort = wr_timing || wr_seq;

	// last conversion of the sequence: index 3 or 7
	assign last = seq[adcstc_pkg::SEQ_LEN_BIT] ? (conv_idx == 3'h7)
		: (conv_idx == 3'h3);

	// next conversion launches when idle, running, and not frozen
	// freeze in finish mode waits here after the current conversion
	assign start_conv = running && !abort && phase == adcstc_pkg::IDLE && !done
		&& !(dbg && freeze_sel != adcstc_pkg::FRZ_RUN);

	// sequencer: slot counter, run state, scan repetition
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			running   <= 1'b0;
			first_seq <= 1'b0;
			conv_idx  <= 3'h0;
		end else if (wr_timing) begin
			running <= 1'b0;
		end else if (wr_seq) begin
			running   <= 1'b1;
			first_seq <= 1'b1;
			conv_idx  <= 3'h0;
		end else if (done) begin
			conv_idx <= last ? 3'h0 : conv_idx + 3'h1;
			if (last) begin
				first_seq <= 1'b0;
				running   <= seq[adcstc_pkg::SEQ_SCAN_BIT];
			end
		end
	end

	// channel select: fixed, or stepping through the group
	always_comb begin
		if (seq[adcstc_pkg::SEQ_MULTICHANNEL_ENABLE_BIT])
			channel = seq[adcstc_pkg::SEQ_LEN_BIT]
				? {seq[3], conv_idx}
				: {seq[3:2], conv_idx[1:0]};
		else
			channel = seq[3:0];
	end

	assign result_index = conv_idx;
	assign sampling     = phase == adcstc_pkg::INIT_SAMPLE
		|| phase == adcstc_pkg::FINAL_SAMPLE;
	assign conv_done    = done;

	////////////////////////////////////////////////////////////////////
	// completion flags; a new sequence write clears them, set wins over read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conversion_done_flag <= 8'h00;
			sequence_done_flag   <= 1'b0;
		end else if (wr_seq) begin
			conversion_done_flag <= 8'h00;
			sequence_done_flag   <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (done && conv_idx == 3'(i))
					conversion_done_flag[i] <= 1'b1;
				else if (result_read[i])
					conversion_done_flag[i] <= 1'b0;
			end
			if (done && last && first_seq)
				sequence_done_flag <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky event bits; hardware set beats write-one clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
		end else begin
			if (wr && addr == adcstc_pkg::OFS_IRQ_MASK)
				irq_mask <= wdata[1:0];
			irq_status[adcstc_pkg::IRQ_SEQ_BIT] <= (done && last && first_seq)
				|| (irq_status[adcstc_pkg::IRQ_SEQ_BIT]
				&& !(wr && addr == adcstc_pkg::OFS_IRQ_STATUS
				&& wdata[adcstc_pkg::IRQ_SEQ_BIT]));
			irq_status[adcstc_pkg::IRQ_CONV_BIT] <= done
				|| (irq_status[adcstc_pkg::IRQ_CONV_BIT]
				&& !(wr && addr == adcstc_pkg::OFS_IRQ_STATUS
				&& wdata[adcstc_pkg::IRQ_CONV_BIT]));
		end
	end

	assign irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses return zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				adcstc_pkg::OFS_FREEZE:     rdata <= {6'h00, freeze_sel};
				adcstc_pkg::OFS_TIMING:     rdata <= timing;
				adcstc_pkg::OFS_SEQUENCE:   rdata <= {1'b0, seq};
				adcstc_pkg::OFS_STATUS:     rdata <= {sequence_done_flag, 4'h0, conv_idx};
				adcstc_pkg::OFS_FLAGS:      rdata <= conversion_done_flag;
				adcstc_pkg::OFS_IRQ_STATUS: rdata <= {6'h00, irq_status};
				adcstc_pkg::OFS_IRQ_MASK:   rdata <= {6'h00, irq_mask};
				default:                    rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule : adcstc_control

/* File: dv/adcstc_properties.sv */
module adcstc_properties (
	input wire logic       clk,                  // clock
	input wire logic       arst_n,               // reset
	input wire logic [7:0] addr,                 // bus
	input wire logic [7:0] wdata,                // bus
	input wire logic       wr,                   // bus
	input wire logic       rd,                   // bus
	input wire logic [7:0] rdata,                // bus
	input wire logic [7:0] result_read,          // clears
	input wire logic [2:0] result_index,         // slot
	input wire logic       sampling,             // core
	input wire logic       ten_bit_resolution,   // mode
	input wire logic       conv_done,            // pulse
	input wire logic [7:0] conversion_done_flag, // flags
	input wire logic       sequence_done_flag    // flag
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_freeze_upper_zero: assert property ($past(rd) && $past(addr) == 8'h63 |-> rdata[7:2] == 6'h00)
		else $error("freeze register upper bits not zero");
	a_res_follows_write: assert property (wr && addr == 8'h64 |=> ten_bit_resolution == $past(wdata[7]))
		else $error("resolution mode not taken from write");
	a_done_one_cycle: assert property (conv_done |=> !conv_done)
		else $error("conversion done longer than one cycle");
	a_start_clears_flags: assert property (wr && addr == 8'h65 |=> conversion_done_flag == 8'h00 && !sequence_done_flag)
		else $error("flags survive a sequence start");
	logic stopped;
	// high from a timing write until the next sequence write; avoids an unbounded until
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			stopped <= 1'b0;
		else if (wr && addr == 8'h64)
			stopped <= 1'b1;
		else if (wr && addr == 8'h65)
			stopped <= 1'b0;
	end
	a_abort_stays_idle: assert property (stopped |-> !sampling && !conv_done)
		else $error("converter active after timing write");
	a_seq_after_conv: assert property ($rose(sequence_done_flag) |-> $past(conv_done))
		else $error("sequence done without a conversion end");
	a_flag_sets_slot: assert property (conv_done && !wr |=> conversion_done_flag[$past(result_index)])
		else $error("slot flag not set after conversion");
	a_read_clears_flag: assert property (result_read != 8'h00 && !conv_done |=> (conversion_done_flag & $past(result_read)) == 8'h00)
		else $error("result read left its flag set");
endmodule : adcstc_properties

bind adcstc_control adcstc_properties u_props (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
	.result_read, .result_index, .sampling, .ten_bit_resolution, .conv_done,
	.conversion_done_flag, .sequence_done_flag);

/* File: dv/adcstc_core_model.sv */
module adcstc_core_model (
	input wire logic       clk,       // clock
	input wire logic       arst_n,    // reset
	input wire logic       sampling,  // switch closed
	input wire logic       conv_done, // result ready
	input wire logic [3:0] channel,   // selected input
	output logic     [3:0] held_ch,   // channel on the capacitor
	output int             n_conv     // conversions seen
);
	// the capacitor keeps the last channel it saw while the switch was closed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held_ch <= 4'h0;
			n_conv  <= 0;
		end else begin
			if (sampling)
				held_ch <= channel;
			if (conv_done)
				n_conv <= n_conv + 1;
		end
	end
endmodule : adcstc_core_model

/* File: dv/adcstc_tb_top.sv */
module adcstc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, arst_n, wr, rd, background_debug_active, sampling, ten_bit_resolution;
	logic       conv_done, sequence_done_flag, irq;
	logic [7:0] addr, wdata, rdata, result_read, conversion_done_flag;
	logic [3:0] channel, held_ch;
	logic [2:0] result_index;
	int         miscompares, checked, n_conv, c, k;
`define chk(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
	adcstc_control dut (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
		.background_debug_active, .result_read, .channel, .result_index, .sampling,
		.ten_bit_resolution, .conv_done, .conversion_done_flag, .sequence_done_flag, .irq);
	adcstc_core_model core (.clk, .arst_n, .sampling, .conv_done, .channel, .held_ch, .n_conv);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	task wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// read slot is only one cycle wide, so sample just after the edge
	task rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `chk(rdata, e)
	endtask : rreg
	task wait_done(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (conv_done !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			miscompares++;
			report_and_stop;
		end
	endtask : wait_done
	task quiet(input int n);
		k = 0;
		repeat (n) begin
			@(posedge clk);
			#1 if (conv_done === 1'b1) k++;
		end
	endtask : quiet
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		rreg(8'h63, 8'h00);
		rreg(8'h64, 8'h01);
		rreg(8'h65, 8'h00);
		wreg(8'h63, 8'hff);
		rreg(8'h63, 8'h03);
		wreg(8'h63, 8'h00);
		rreg(8'h40, 8'h00);
	endtask : t_regs
	// interval between two conversion ends, tolerant of tick phase
	task t_timing;
		logic [7:0] cfg [8];
		int t, dv;
		cfg = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'he0, 8'h01, 8'h07};
		foreach (cfg[i]) begin
			// at a 100 MHz p clock no legal code reaches the rate window; ratios only
			wreg(8'h64, cfg[i]);
			wreg(8'h65, 8'h00);
			wait_done(c);
			wait_done(c);
			`chk(ten_bit_resolution, cfg[i][7])
			t = 16 + (2 << cfg[i][6:5]) + (cfg[i][7] ? 2 : 0);
			dv = cfg[i][4:0] == 5'h00 ? 2 : 2 * (cfg[i][4:0] + 1);
			`chk(c >= (t - 1) * dv && c <= (t + 1) * dv + 2, 1'b1)
			wait_done(c);
			wait_done(c);
			@(posedge clk);
			#1 `chk(conversion_done_flag, 8'h0f)
			`chk(sequence_done_flag, 1'b1)
			@(posedge clk);
			result_read <= 8'h05;
			@(posedge clk);
			result_read <= 8'h00;
			#1 `chk(conversion_done_flag, 8'h0a)
			quiet(t * dv + 2 * dv + 4);
			`chk(k, 0)
		end
		wreg(8'h64, 8'h00);
	endtask : t_timing
	task t_modes;
		logic [7:0] sq [3];
		logic [3:0] ex;
		int         n0;
		sq = '{8'h15, 8'h06, 8'h50};
		foreach (sq[j]) begin
			n0 = n_conv;
			wreg(8'h65, sq[j]);
			for (int i = 0; i < (sq[j][6] ? 8 : 4); i++) begin
				wait_done(c);
				ex = sq[j][4] ? (sq[j][6] ? {sq[j][3], 3'(i)} : {sq[j][3:2], 2'(i)}) : sq[j][3:0];
				`chk(held_ch, ex)
				`chk(result_index, 3'(i))
			end
			@(posedge clk);
			#1 `chk(conversion_done_flag, sq[j][6] ? 8'hff : 8'h0f)
			`chk(n_conv, n0 + (sq[j][6] ? 8 : 4))
			rreg(8'h66, 8'h80);
			rreg(8'h67, sq[j][6] ? 8'hff : 8'h0f);
		end
	endtask : t_modes
	// scan keeps going, but the sequence event fires only once
	task t_scan;
		wreg(8'h71, 8'h03);
		wreg(8'h65, 8'h20);
		repeat (4) wait_done(c);
		@(posedge clk);
		#1 `chk(irq, 1'b1)
		wreg(8'h70, 8'h03);
		wreg(8'h71, 8'h01);
		repeat (5) wait_done(c);
		`chk(irq, 1'b0)
		rreg(8'h70, 8'h02);
		wreg(8'h64, 8'h00);
		quiet(300);
		`chk(k, 0)
		wreg(8'h65, 8'h00);
		wait_done(c);
		wreg(8'h65, 8'h00);
		#1 `chk(conversion_done_flag, 8'h00)
	endtask : t_scan
	task t_freeze;
		logic [1:0] code [3];
		int exp_k [3];
		code = '{2'h3, 2'h2, 2'h0};
		exp_k = '{0, 1, 4};
		foreach (code[i]) begin
			wreg(8'h63, {6'h00, code[i]});
			wreg(8'h65, 8'h00);
			repeat (10) @(posedge clk);
			background_debug_active <= 1'b1;
			quiet(300);
			`chk(k, exp_k[i])
			@(posedge clk);
			background_debug_active <= 1'b0;
			if (code[i] != 2'h0)
				wait_done(c);
		end
	endtask : t_freeze
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		background_debug_active = 1'b0;
		result_read = 8'h00;
		miscompares = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_timing;
		t_modes;
		t_scan;
		t_freeze;
		report_and_stop;
	end
endmodule : adcstc_tb_top
